// >>> tb/usart_sync_slave_mode_bench.sv
// Purpose: Self-checking bench for the synchronous slave serial port.
// Assumes: Link period is 8 clk cycles; the bus wait is read from waitrequest.
// Notes:   Sleep has no port here, so only link-clocked behaviour is seen.
`default_nettype none

module usart_sync_slave_mode_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import uss_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [9:0]  address = 10'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        shift_clock_pin;
  logic        data_pin_in;
  logic        data_pin_out;
  logic        data_pin_oe;
  logic        wake_request;
  logic        interrupt_request;
  int          errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          i;
  logic [7:0]  q;
  logic [8:0]  got;
  logic [8:0]  e;
  logic [8:0]  mq[$];
  uss_word_t   w[3];
  logic [7:0]  ridx[8] = '{8'h0b, 8'h0c, 8'h18, 8'h1a, 8'h8c, 8'h98, 8'h99, 8'h10};
  logic [8:0]  rval[8] = '{9'h0, 9'h10, 9'h0, 9'h0, 9'h0, 9'h02, 9'h0, 9'h0};

  always #12.5 clk = ~clk;

  uss_top u_uss_top (.clk(clk), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .byteenable(4'h1), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .shift_clock_pin(shift_clock_pin),
    .data_pin_in(data_pin_in), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
    .wake_request(wake_request), .interrupt_request(interrupt_request));

  uss_master_model u_uss_master_model (.clk(clk), .shift_clock_pin(shift_clock_pin),
    .data_pin_in(data_pin_in), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe));

  // ==========================================================================
  // Tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Completion and read data are both taken at the edge where waitrequest is seen low.
  task automatic acc(input logic w_n, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    address <= {idx, 2'b00};
    read <= !w_n;
    write <= w_n;
    writedata <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [8:0] exp);
    acc(1'b0, idx, 8'h0);
    chk({1'b0, q}, exp);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors++;
      summarize();
    end
  end

  // ==========================================================================
  // Tests
  initial begin
    void'($urandom(9));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 8; i++) rd(ridx[i], rval[i]);
    $display("test reset done");
    foreach (w[i]) w[i] = 9'($urandom);
    w[1].ninth = w[0].ninth;
    acc(1'b1, 8'h18, 8'h80);
    acc(1'b1, 8'h98, {7'h38, w[0].ninth});
    acc(1'b1, 8'h8c, 8'h10);
    acc(1'b1, 8'h0b, 8'hc0);
    for (i = 0; i < 2; i++) begin
      acc(1'b1, 8'h19, w[i].data);
      mq.push_back(w[i]);
    end
    rd(8'h0c, 9'h0);
    rd(8'h98, {1'b0, 7'h38, w[0].ninth});
    u_uss_master_model.xfer(9'h0, 9, 4, got);
    chk(got, mq.pop_front());
    rd(8'h0c, 9'h10);
    @(negedge clk);
    chk({8'h0, interrupt_request}, 9'h1);
    u_uss_master_model.xfer(9'h0, 9, 4, got);
    chk(got, mq.pop_front());
    rd(8'h98, {1'b0, 7'h39, w[0].ninth});
    $display("test transmit done");
    acc(1'b1, 8'h98, 8'h10);
    acc(1'b1, 8'h18, 8'ha0);
    u_uss_master_model.xfer(9'h0a5, 8, 4, got);
    rd(8'h0c, 9'h10);
    acc(1'b1, 8'h8c, 8'h20);
    acc(1'b1, 8'h18, 8'hd0);
    for (i = 0; i < 3; i++) begin
      w[i] = 9'($urandom);
      u_uss_master_model.xfer(w[i], 9, 4, got);
      if (mq.size() < 2) mq.push_back(w[i]);
      rd(8'h0c, 9'h30);
      @(negedge clk);
      chk({7'h0, wake_request, interrupt_request}, 9'h3);
    end
    while (mq.size() > 0) begin
      e = mq.pop_front();
      rd(8'h18, {1'b0, 7'h69, e[8]});
      rd(8'h1a, {1'b0, e[7:0]});
    end
    rd(8'h0c, 9'h10);
    acc(1'b1, 8'h18, 8'hc0);
    rd(8'h18, 9'h0c0);
    acc(1'b1, 8'h18, 8'hd0);
    u_uss_master_model.xfer(w[2], 9, 4, got);
    rd(8'h18, {1'b0, 7'h68, w[2].ninth});
    rd(8'h1a, {1'b0, w[2].data});
    $display("test receive done");
    acc(1'b1, 8'h18, 8'h90);
    u_uss_master_model.xfer({1'b0, w[0].data}, 8, 4, got);
    rd(8'h18, 9'h090);
    rd(8'h1a, {1'b0, w[0].data});
    acc(1'b1, 8'h18, 8'h80);
    acc(1'b1, 8'h98, 8'h30);
    acc(1'b1, 8'h19, w[1].data);
    u_uss_master_model.xfer(9'h0, 8, 4, got);
    chk(got, {1'b0, w[1].data});
    $display("test eight bit done");
    summarize();
  end
endmodule // usart_sync_slave_mode_bench

bind uss_top uss_checker u_uss_checker (.clk(clk), .rst_b(rst_b), .read(read),
  .write(write), .waitrequest(waitrequest), .shift_clock_pin(shift_clock_pin),
  .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
  .wake_request(wake_request), .interrupt_request(interrupt_request));

`default_nettype wire

// >>> tb/uss_checker.sv
// Purpose: Port checker for the synchronous slave serial port.
// Assumes: One clock domain; sees only the ports of uss_top.
// Notes:   age counts clk cycles since the last shift clock fall.
`default_nettype none

module uss_checker (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Register bus.
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic        waitrequest,
  // Link and requests.
  input  wire logic        shift_clock_pin,
  input  wire logic        data_pin_out,
  input  wire logic        data_pin_oe,
  input  wire logic        wake_request,
  input  wire logic        interrupt_request
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] age;
  logic       tk;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ==========================================================================
  // Helper logic
  assign tk = (read || write) && !waitrequest;

  // Saturates so that a stalled link never looks like a fresh edge.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) age <= 4'hf;
    else if ($fell(shift_clock_pin)) age <= 4'h0;
    else if (age != 4'hf) age <= age + 4'h1;
  end

  // ==========================================================================
  // Properties
  sequence s_start;
    (read || write) && !$past(read || write);
  endsequence
  sequence s_taken;
    tk;
  endsequence

  property p_wait_first;
    s_start |-> waitrequest;
  endproperty
  property p_one_wait;
    s_start |=> s_taken;
  endproperty
  property p_irq;
    interrupt_request |-> wake_request;
  endproperty
  property p_out;
    $changed(data_pin_out) && $past(data_pin_oe) && data_pin_oe |-> age inside {[1:6]};
  endproperty
  property p_oe_rise;
    $rose(data_pin_oe) |-> $past(tk, 2) || age inside {[2:4]};
  endproperty
  property p_oe_fall;
    $fell(data_pin_oe) |-> age inside {[1:7]} || $past(tk, 2);
  endproperty
  property p_wake_rise;
    $rose(wake_request) |-> age inside {[1:8]} || $past(tk, 2) || $past(tk, 3);
  endproperty
  property p_wake_fall;
    $fell(wake_request) |-> $past(tk, 2) || $past(tk, 3);
  endproperty

  a_wait_first: assert property (p_wait_first) else $error("no wait state");
  a_one_wait: assert property (p_one_wait) else $error("access not done in 2 cycles");
  a_irq: assert property (p_irq) else $error("interrupt without wake");
  a_out: assert property (p_out) else $error("data moved off a clock fall");
  a_oe_rise: assert property (p_oe_rise) else $error("drive began without a write");
  a_oe_fall: assert property (p_oe_fall) else $error("drive ended off a fall");
  a_wake_rise: assert property (p_wake_rise) else $error("wake rose without cause");
  a_wake_fall: assert property (p_wake_fall) else $error("wake fell without access");
endmodule // uss_checker

`default_nettype wire

// >>> tb/uss_master_model.sv
// Purpose: External synchronous master that clocks words in and out.
// Assumes: Clock idles high; both sides act on the falling edge.
// Notes:   Data line shows the inverse of its last bit between frames.
`default_nettype none

module uss_master_model (
  // Reference clock.
  input  wire logic clk,
  // Link pins.
  output logic      shift_clock_pin,
  output logic      data_pin_in,
  input  wire logic data_pin_out,
  input  wire logic data_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial shift_clock_pin = 1'b1;
  initial data_pin_in = 1'b0;

  // One frame, LSB first; half sets the link speed in clk cycles.
  task automatic xfer(input logic [8:0] tx, input int n, input int half,
                      output logic [8:0] rx);
    int i;
    rx = 9'h0;
    @(posedge clk);
    for (i = 0; i < n; i++) begin
      data_pin_in <= tx[i];
      repeat (half) @(posedge clk);
      rx[i] = data_pin_oe ? data_pin_out : 1'bx;
      shift_clock_pin <= 1'b0;
      repeat (half) @(posedge clk);
      shift_clock_pin <= 1'b1;
    end
    data_pin_in <= ~tx[n-1];
  endtask
endmodule // uss_master_model

`default_nettype wire

// >>> verilog/uss_cfg.svh
// Purpose: Offsets, field positions, reset values and counts of the serial port.
// Assumes: Register index times four gives the Avalon byte address.
// Notes:   Definitions only.
`ifndef USS_CFG_SVH
`define USS_CFG_SVH

// ==========================================================================
// Register indices
`define USS_IDX_INTCTL   8'h0b
`define USS_IDX_PFLAGS   8'h0c
`define USS_IDX_RXCTL    8'h18
`define USS_IDX_TXDATA   8'h19
`define USS_IDX_RXDATA   8'h1a
`define USS_IDX_PENABLE  8'h8c
`define USS_IDX_TXCTL    8'h98
`define USS_IDX_BAUD     8'h99

// ==========================================================================
// Reset values
`define USS_RST_INTCTL   8'h00
`define USS_RST_PFLAGS   8'h00
`define USS_RST_RXCTL    8'h00
`define USS_RST_PENABLE  8'h00
`define USS_RST_TXCTL    8'h02
`define USS_RST_BAUD     8'h00

// ==========================================================================
// Field positions
`define USS_B_GIE        7
`define USS_B_PERIPHERAL_INTERRUPT_ENABLE       6
`define USS_B_RECEIVE_BUFFER_FULL_FLAG       5
`define USS_B_TRANSMIT_BUFFER_EMPTY_FLAG       4
`define USS_B_SERIAL_PORT_ENABLE       7
`define USS_B_RX9        6
`define USS_B_SINGLE_RECEIVE_ENABLE       5
`define USS_B_CONTINUOUS_RECEIVE_ENABLE       4
`define USS_B_ADDRESS_DETECT_ENABLE      3
`define USS_B_FRAMING_ERROR_FLAG       2
`define USS_B_OVERRUN_ERROR_FLAG       1
`define USS_B_RECEIVE_NINTH_BIT       0
`define USS_B_CLOCK_SOURCE_SELECT       7
`define USS_B_TX9        6
`define USS_B_TRANSMIT_ENABLE       5
`define USS_B_SYNC       4
`define USS_B_HIGH_BAUD_SELECT       2
`define USS_B_SHIFTER_EMPTY_STATUS       1
`define USS_B_TRANSMIT_NINTH_BIT       0

// ==========================================================================
// Counts
`define USS_LAST_BIT8    4'd7
`define USS_LAST_BIT9    4'd8
`define USS_FIFO_DEPTH   2'd2

`endif

// >>> verilog/uss_pkg.sv
// Purpose: Types shared by the serial port design and its bench.
// Assumes: Nothing beyond the configuration header.
// Notes:   A word carries eight data bits and an optional ninth bit.
`default_nettype none

package uss_pkg;
  // ========================================================================
  // Word carried through the shifters and the receive queue
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } uss_word_t;
endpackage

`default_nettype wire

// >>> verilog/uss_top.sv
// Purpose: Synchronous slave serial port with Avalon-MM registers.
// Assumes: The shift clock pin is far slower than clk and is synchronised here.
// Notes:   All logic, shifting included, runs on clk through the pin synchronisers; there is no sleep input.
// Functional notes
// RULE_01: Cleared clock source bit selects external shift clock.
// RULE_02: Shifting continues while the chip sleeps.
// RULE_03: First buffered word moves to shifter at once.
// RULE_04: Second word waits; transmit empty flag stays clear.
// RULE_05: After shift-out, reload shifter, set transmit flag.
// RULE_06: Transmit flag with enable wakes and interrupts.
// RULE_07: Software sets up sync slave transmit bits.
// RULE_08: Software enables, loads ninth bit, then data.
// RULE_09: Single receive enable ignored in slave mode.
// RULE_10: Continuous receive accepts words during sleep.
// RULE_11: Completed word goes to buffer; wakes when enabled.
// RULE_12: Software sets up slave receive, then enables.
// RULE_13: Completed reception sets receive full flag.
// RULE_14: Software reads status before received data.
// RULE_15: Clearing continuous receive clears error flags.
// RULE_16: Software sets global and peripheral enables.
// RULE_17: Software keeps reserved parallel port bits clear.
// RULE_18: Software writes ninth bit before data.
// RULE_19: Two-word receive queue; overrun drops and blocks.
// RULE_20: Shifter empty status reflects shifter and buffer.
//
// Implementation choice: register access over Avalon-MM.
`default_nettype none
`include "uss_cfg.svh"

module uss_top (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Avalon-MM register slave.
  input  wire logic [9:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Link pins.
  input  wire logic        shift_clock_pin,
  input  wire logic        data_pin_in,
  output logic             data_pin_out,
  output logic             data_pin_oe,
  // Wake and interrupt requests to the core.
  output logic             wake_request,
  output logic             interrupt_request
);
  import uss_pkg::*;

  // ==========================================================================
  // Declarations
  logic            ack;
  logic            done;
  logic            wr_en;
  logic [7:0]      idx;
  logic [7:0]      int_ctl;
  logic [7:0]      pflags;
  logic [7:0]      penable;
  logic [7:0]      rx_ctl;
  logic [7:0]      tx_ctl;
  logic [7:0]      baud;
  logic [7:0]      rd_mux;
  logic [7:0]      tx_buf;
  logic            tx_buf_full;
  logic            tx_on;
  logic            tx_load;
  logic            tsr_busy;
  logic            tsr_nine;
  logic [8:0]      transmit_shifter;
  logic [3:0]      tcnt;
  logic            rx_on;
  logic [8:0]      receive_shifter;
  logic [3:0]      rcnt;
  logic [8:0]      next_rsr;
  logic [3:0]      rx_last;
  logic            rx_done;
  uss_word_t       rx_word;
  uss_word_t       fifo [2];
  logic            rd_ptr;
  logic [1:0]      fcnt;
  logic            push;
  logic            pop;
  logic            overrun_error_flag;
  logic            ck_s1;
  logic            ck_s2;
  logic            ck_s3;
  logic            dt_s1;
  logic            dt_s2;
  logic            ck_fall;
  logic            transmit_buffer_empty_flag;
  logic            receive_buffer_full_flag;
  logic            shifter_empty_status;
  logic            slave_mode;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] i);
    return a == i;
  endfunction

  // ==========================================================================
  // Avalon access: one wait state, then the access completes.
  assign idx         = address[9:2];
  assign waitrequest = (read | write) & ~ack;
  assign done        = (read | write) & ack;
  assign wr_en       = done & write & byteenable[0];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack <= 1'b0;
    end else begin
      ack <= (read | write) & ~ack;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack) begin
      readdata <= {24'h00_0000, rd_mux};
    end
  end

  // ==========================================================================
  // Software-written registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int_ctl <= `USS_RST_INTCTL;
      pflags  <= `USS_RST_PFLAGS;
      penable <= `USS_RST_PENABLE;
      rx_ctl  <= `USS_RST_RXCTL;
      tx_ctl  <= `USS_RST_TXCTL;
      baud    <= `USS_RST_BAUD;
    end else if (wr_en) begin
      if (hit(idx, `USS_IDX_INTCTL)) begin
        int_ctl <= writedata[7:0];
      end
      if (hit(idx, `USS_IDX_PFLAGS)) begin
        pflags <= writedata[7:0];
      end
      if (hit(idx, `USS_IDX_PENABLE)) begin
        penable <= writedata[7:0];
      end
      if (hit(idx, `USS_IDX_RXCTL)) begin
        rx_ctl <= writedata[7:0];
      end
      if (hit(idx, `USS_IDX_TXCTL)) begin
        tx_ctl <= writedata[7:0];
      end
      if (hit(idx, `USS_IDX_BAUD)) begin
        baud <= writedata[7:0];
      end
    end
  end

  // ==========================================================================
  // Status and read mux
  assign transmit_buffer_empty_flag = ~tx_buf_full;
  assign receive_buffer_full_flag = fcnt != 2'd0; // RULE_13
  assign shifter_empty_status = ~tsr_busy & ~tx_buf_full; // RULE_20

  always_comb begin
    rd_mux = 8'h00;
    if (hit(idx, `USS_IDX_INTCTL)) begin
      rd_mux = int_ctl;
    end else if (hit(idx, `USS_IDX_PFLAGS)) begin
      rd_mux = pflags;
      rd_mux[`USS_B_RECEIVE_BUFFER_FULL_FLAG] = receive_buffer_full_flag;
      rd_mux[`USS_B_TRANSMIT_BUFFER_EMPTY_FLAG] = transmit_buffer_empty_flag; // RULE_04
    end else if (hit(idx, `USS_IDX_PENABLE)) begin
      rd_mux = penable;
    end else if (hit(idx, `USS_IDX_RXCTL)) begin
      rd_mux = rx_ctl;
      rd_mux[`USS_B_FRAMING_ERROR_FLAG] = 1'b0;
      rd_mux[`USS_B_OVERRUN_ERROR_FLAG] = overrun_error_flag;
      rd_mux[`USS_B_RECEIVE_NINTH_BIT] = fifo[rd_ptr].ninth & receive_buffer_full_flag;
    end else if (hit(idx, `USS_IDX_RXDATA)) begin
      rd_mux = receive_buffer_full_flag ? fifo[rd_ptr].data : 8'h00;
    end else if (hit(idx, `USS_IDX_TXCTL)) begin
      rd_mux = tx_ctl;
      rd_mux[3] = 1'b0;
      rd_mux[`USS_B_SHIFTER_EMPTY_STATUS] = shifter_empty_status;
    end else if (hit(idx, `USS_IDX_BAUD)) begin
      rd_mux = baud;
    end
  end

  // ==========================================================================
  // Pin synchronisers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
      dt_s1 <= 1'b0;
      dt_s2 <= 1'b0;
    end else begin
      ck_s1 <= shift_clock_pin;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      dt_s1 <= data_pin_in;
      dt_s2 <= dt_s1;
    end
  end

  // The master samples and we advance on the falling edge of its clock.
  assign ck_fall    = ck_s3 & ~ck_s2; // RULE_01
  assign slave_mode = rx_ctl[`USS_B_SERIAL_PORT_ENABLE] & tx_ctl[`USS_B_SYNC] & ~tx_ctl[`USS_B_CLOCK_SOURCE_SELECT]; // RULE_01

  // ==========================================================================
  // Transmit buffer and shifter
  assign tx_on   = slave_mode & tx_ctl[`USS_B_TRANSMIT_ENABLE];
  assign tx_load = tx_on & tx_buf_full & ~tsr_busy; // RULE_03 RULE_05

  // A write in the cycle of a load keeps the buffer full with the new word.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_buf      <= 8'h00;
      tx_buf_full <= 1'b0;
    end else if (wr_en && hit(idx, `USS_IDX_TXDATA)) begin
      tx_buf      <= writedata[7:0];
      tx_buf_full <= 1'b1;
    end else if (tx_load) begin
      tx_buf_full <= 1'b0; // RULE_05
    end
  end

  // Dropping the enable aborts the word in the shifter; the buffer is kept.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      transmit_shifter      <= 9'h000;
      tsr_busy <= 1'b0;
      tsr_nine <= 1'b0;
      tcnt     <= 4'd0;
    end else if (!tx_on) begin
      tsr_busy <= 1'b0;
      tcnt     <= 4'd0;
    end else if (tx_load) begin
      transmit_shifter      <= {tx_ctl[`USS_B_TRANSMIT_NINTH_BIT], tx_buf}; // RULE_03
      tsr_nine <= tx_ctl[`USS_B_TX9];
      tsr_busy <= 1'b1;
      tcnt     <= 4'd0;
    end else if (tsr_busy && ck_fall) begin // RULE_02
      if (tcnt == (tsr_nine ? `USS_LAST_BIT9 : `USS_LAST_BIT8)) begin
        tsr_busy <= 1'b0; // RULE_05
        tcnt     <= 4'd0;
      end else begin
        transmit_shifter  <= {1'b0, transmit_shifter[8:1]};
        tcnt <= tcnt + 4'd1;
      end
    end
  end

  assign data_pin_out = transmit_shifter[0];
  assign data_pin_oe  = tsr_busy & ~rx_on;

  // ==========================================================================
  // Receive shifter; the single receive enable plays no part here.
  assign rx_on    = slave_mode & rx_ctl[`USS_B_CONTINUOUS_RECEIVE_ENABLE]; // RULE_09 RULE_10
  assign rx_last  = rx_ctl[`USS_B_RX9] ? `USS_LAST_BIT9 : `USS_LAST_BIT8;
  assign next_rsr = {dt_s2, receive_shifter[8:1]};
  assign rx_done  = rx_on & ck_fall & (rcnt == rx_last); // RULE_02

  always_comb begin
    if (rx_ctl[`USS_B_RX9]) begin
      rx_word.data  = next_rsr[7:0];
      rx_word.ninth = next_rsr[8];
    end else begin
      rx_word.data  = next_rsr[8:1];
      rx_word.ninth = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      receive_shifter  <= 9'h000;
      rcnt <= 4'd0;
    end else if (!rx_on) begin
      rcnt <= 4'd0;
    end else if (ck_fall) begin
      receive_shifter  <= next_rsr;
      rcnt <= (rcnt == rx_last) ? 4'd0 : rcnt + 4'd1;
    end
  end

  // ==========================================================================
  // Two-word receive queue and overrun
  assign push = rx_done & ~overrun_error_flag & (fcnt != `USS_FIFO_DEPTH); // RULE_11 RULE_19
  assign pop  = done & read & hit(idx, `USS_IDX_RXDATA) & receive_buffer_full_flag;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ptr <= 1'b0;
      fcnt   <= 2'd0;
    end else begin
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push && !pop) begin
        fcnt <= fcnt + 2'd1;
      end else if (pop && !push) begin
        fcnt <= fcnt - 2'd1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      fifo[rd_ptr ^ fcnt[0]] <= rx_word; // RULE_11
    end
  end

  // Overrun stays set, blocking the queue, until the continuous receive enable is cleared.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      overrun_error_flag <= 1'b0;
    end else if (rx_done && !overrun_error_flag && fcnt == `USS_FIFO_DEPTH) begin
      overrun_error_flag <= 1'b1; // RULE_19
    end else if (!rx_ctl[`USS_B_CONTINUOUS_RECEIVE_ENABLE]) begin
      overrun_error_flag <= 1'b0; // RULE_15
    end
  end

  // ==========================================================================
  // Wake and interrupt requests
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_request      <= 1'b0;
      interrupt_request <= 1'b0;
    end else begin
      wake_request <= (transmit_buffer_empty_flag & penable[`USS_B_TRANSMIT_BUFFER_EMPTY_FLAG])
                    | (receive_buffer_full_flag & penable[`USS_B_RECEIVE_BUFFER_FULL_FLAG]); // RULE_06 RULE_11
      interrupt_request <= ((transmit_buffer_empty_flag & penable[`USS_B_TRANSMIT_BUFFER_EMPTY_FLAG])
                          | (receive_buffer_full_flag & penable[`USS_B_RECEIVE_BUFFER_FULL_FLAG]))
                          & int_ctl[`USS_B_GIE] & int_ctl[`USS_B_PERIPHERAL_INTERRUPT_ENABLE]; // RULE_06 RULE_13
    end
  end

endmodule // uss_top

`default_nettype wire
